// ===== hw/fsw_defs.vh
// Constants for the flash status and write-protect block.
// Assumes a 50 MHz system clock and a serial host in SPI mode 0 or 3.
`ifndef FSW_DEFS_VH
`define FSW_DEFS_VH

// Command codes
`define FSW_OP_LATCH_SET 8'h06
`define FSW_OP_LATCH_CLR 8'h04
`define FSW_OP_RD_SR1 8'h05
`define FSW_OP_RD_SR2 8'h35
`define FSW_OP_RD_SR3 8'h15
`define FSW_OP_WR_SR1 8'h01
`define FSW_OP_WR_SR2 8'h31
`define FSW_OP_WR_SR3 8'h11
`define FSW_OP_PAGE 8'h02
`define FSW_OP_WIPE_4K 8'h20
`define FSW_OP_WIPE_32K 8'h52
`define FSW_OP_WIPE_64K 8'hD8
`define FSW_OP_WIPE_ALL_A 8'h60
`define FSW_OP_WIPE_ALL_B 8'hC7
`define FSW_OP_RST_ARM 8'h66
`define FSW_OP_RST_GO 8'h99

// Field positions within each status byte
`define FSW_SR1_LOCK_LO 7
`define FSW_SR2_INVERT 6
`define FSW_SR2_FOUR_LANE 1
`define FSW_SR2_LOCK_HI 0
`define FSW_SR3_PIN_SEL 7
`define FSW_SR3_LATENCY 0

// Power-up values (drive strength defaults to 01)
`define FSW_SR1_RST 8'h00
`define FSW_SR2_RST 8'h00
`define FSW_SR3_RST 8'h20

// Array operation kinds reported to the array sequencer
`define FSW_KIND_PAGE 2'h0
`define FSW_KIND_SMALL 2'h1
`define FSW_KIND_MID 2'h2
`define FSW_KIND_WHOLE 2'h3

// Cycles the busy flag stands after an accepted operation
`define FSW_BUSY_CYC 16'h0064

`endif

// ===== hw/fsw_sync.v
// Two-stage synchroniser for pins arriving from outside the clock domain.
// Assumes the reset value given matches the idle level of each pin.
`timescale 1ns/1ns
module fsw_sync #(
  parameter W = 1,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire i_clk, // System clock
  input wire i_rst_n, // Synchronous-release reset, active low
  input wire [W-1:0] i_d, // Asynchronous inputs
  output wire [W-1:0] o_q // Synchronised outputs
);
  reg [W-1:0] meta_r;
  reg [W-1:0] hold_r;

  // First stage is read only by the second stage
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_r <= RST_VAL;
      hold_r <= RST_VAL;
    end else begin
      meta_r <= i_d;
      hold_r <= meta_r;
    end
  end

  assign o_q = hold_r;
endmodule // fsw_sync

// ===== hw/fsw_region.v
// Protected-range decoder: select bits and invert bit against a 24-bit address.
// Assumes a 16 MB array; purely combinational, registered by the caller.
`timescale 1ns/1ns
module fsw_region (
  input wire [4:0] i_sel, // Region select bits
  input wire i_invert, // Complement the range
  input wire [23:0] i_addr, // Target byte address
  output reg o_protected, // Address lies in protected range
  output reg o_chip_ok // Whole-array wipe permitted
);
  reg [2:0] low;
  reg [4:0] sh;
  reg [23:0] mask;
  reg in_rng;

  // Range size is a power of two, so a top or bottom test is a masked compare
  always @* begin
    low = i_sel[2:0];
    sh = 5'd0;
    mask = 24'h00_0000;
    in_rng = 1'b0;
    if (low == 3'h7) begin
      in_rng = 1'b1;
    end else if (low != 3'h0) begin
      if (!i_sel[4]) begin
        sh = 5'd17 + {2'b00, low};
      end else if (low[2]) begin
        sh = 5'd15;
      end else begin
        sh = 5'd11 + {3'b000, low[1:0]};
      end
      mask = 24'hFF_FFFF << sh;
      in_rng = i_sel[3] ? ((i_addr & mask) == 24'h00_0000) : ((i_addr & mask) == mask);
    end
    o_protected = in_rng ^ i_invert;
    o_chip_ok = ((low == 3'h0) && !i_invert) || ((low == 3'h7) && i_invert);
  end
endmodule // fsw_region

// ===== hw/fsw_top.v
// Status bytes and write-protection logic of a serial NOR flash.
// Assumes the host drives the serial pins asynchronously; all are
// sampled by i_clk, which must run well above the serial clock.
`timescale 1ns/1ns
`include "fsw_defs.vh"
module fsw_top #(
  parameter [15:0] BUSY_CYC = `FSW_BUSY_CYC
) (
  input wire i_clk, // System clock, 50 MHz
  input wire i_rst_n, // Power-up reset, active low
  input wire i_sclk, // Serial clock from host
  input wire i_cs_n, // Chip select, active low
  input wire i_si, // Serial data in
  input wire i_wp_n, // Write-protect pin, active low
  input wire i_erase_paused, // Erase suspended, from array logic
  input wire i_prog_paused, // Program suspended, from array logic
  output reg o_so, // Serial data out
  output reg o_so_oe, // Serial out drive enable
  output reg o_array_go, // One-cycle start of an array operation
  output reg [1:0] o_array_kind, // Kind of array operation
  output reg [23:0] o_array_addr, // Address of array operation
  output reg o_busy_flag, // Operation in progress
  output reg o_four_lane_on, // Four-lane mode enable
  output reg [1:0] o_drive_strength, // Output drive strength
  output reg o_latency_select, // Read latency select
  output reg o_pause_or_reset_select, // Pin function select
  output reg [2:0] o_lock_otp // Security-area lock bits
);

  // Reset release through two flops
  reg rst_meta_r;
  reg rst_sync_r;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end
  wire rst_n = rst_sync_r;

  // Power-up images of the three bytes; reset fields are cut from these
  // so that every reset value keeps the width of the flop it loads
  localparam [7:0] SR1_RST = `FSW_SR1_RST;
  localparam [7:0] SR2_RST = `FSW_SR2_RST;
  localparam [7:0] SR3_RST = `FSW_SR3_RST;

  // Pin sampling: cs_n and wp_n idle high, sclk idle low
  // A pin change is seen about three clocks late, so each serial clock
  // phase must last at least four system clocks
  wire [3:0] pins_s;
  fsw_sync #(
    .W(4),
    .RST_VAL(4'h9)
  ) u_sync (
    .i_clk(i_clk),
    .i_rst_n(rst_n),
    .i_d({i_cs_n, i_sclk, i_si, i_wp_n}),
    .o_q(pins_s)
  );
  wire cs_s = pins_s[3];
  wire sclk_s = pins_s[2];
  wire si_s = pins_s[1];
  wire wp_s = pins_s[0];

  // Edge history, taken only from the second synchroniser stage
  reg sclk_d_r;
  reg cs_d_r;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
    end else begin
      sclk_d_r <= sclk_s;
      cs_d_r <= cs_s;
    end
  end
  wire sclk_rise = sclk_s & ~sclk_d_r & ~cs_s;
  wire sclk_fall = ~sclk_s & sclk_d_r & ~cs_s;
  wire cs_end = cs_s & ~cs_d_r;

  // Status byte number addressed by a read or write opcode, zero if neither
  function [1:0] fsw_sel;
    input [7:0] op;
    begin
      case (op)
        `FSW_OP_RD_SR1, `FSW_OP_WR_SR1: fsw_sel = 2'h1;
        `FSW_OP_RD_SR2, `FSW_OP_WR_SR2: fsw_sel = 2'h2;
        `FSW_OP_RD_SR3, `FSW_OP_WR_SR3: fsw_sel = 2'h3;
        default: fsw_sel = 2'h0;
      endcase
    end
  endfunction

  // Opcode is one of the three status reads
  function fsw_is_rd;
    input [7:0] op;
    begin
      fsw_is_rd = (op == `FSW_OP_RD_SR1) || (op == `FSW_OP_RD_SR2) || (op == `FSW_OP_RD_SR3);
    end
  endfunction

  // Stored status bits
  reg lock_lo_r;
  reg lock_hi_r;
  reg [4:0] region_r;
  reg invert_r;
  reg latch_r;
  reg [15:0] busy_cnt_r;
  // The array sequencer reports no completion, so every accepted operation
  // holds busy for the same BUSY_CYC clocks; a slower array needs a
  // longer count
  wire busy_w = (busy_cnt_r != 16'h0000);

  // Byte images as the host sees them; reserved bits read zero
  wire [7:0] sr1_w = {lock_lo_r, region_r, latch_r, busy_w};
  wire [7:0] sr2_w = {i_erase_paused, invert_r, o_lock_otp, i_prog_paused,
                      o_four_lane_on, lock_hi_r};
  wire [7:0] sr3_w = {o_pause_or_reset_select, o_drive_strength, 4'h0,
                      o_latency_select};

  // Serial receive state
  reg [2:0] bitcnt_r;
  reg [2:0] bytecnt_r;
  reg [7:0] shin_r;
  reg [7:0] cmd_r;
  reg [7:0] data_r;
  reg [23:0] addr_r;
  reg reading_r;
  reg [1:0] rd_sel_r;
  reg [7:0] tx_r;
  reg [2:0] txcnt_r;
  wire [7:0] byte_in = {shin_r[6:0], si_s};

  // Fresh image of the byte being polled
  reg [7:0] rd_img;
  always @* begin
    case (rd_sel_r)
      2'h1: rd_img = sr1_w;
      2'h2: rd_img = sr2_w;
      2'h3: rd_img = sr3_w;
      default: rd_img = 8'h00;
    endcase
  end

  // Shifter: bytes in on rising edges, status out on falling edges
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bitcnt_r <= 3'h0;
      bytecnt_r <= 3'h0;
      shin_r <= 8'h00;
      cmd_r <= 8'h00;
      data_r <= 8'h00;
      addr_r <= 24'h00_0000;
      reading_r <= 1'b0;
      rd_sel_r <= 2'h0;
      tx_r <= 8'h00;
      txcnt_r <= 3'h0;
      o_so <= 1'b0;
      o_so_oe <= 1'b0;
    end else if (cs_s) begin
      // Deselect drops any partial byte and lets go of the output at once
      bitcnt_r <= 3'h0;
      bytecnt_r <= 3'h0;
      reading_r <= 1'b0;
      txcnt_r <= 3'h0;
      o_so_oe <= 1'b0;
    end else begin
      if (sclk_rise) begin
        shin_r <= byte_in;
        bitcnt_r <= bitcnt_r + 3'h1;
        if (bitcnt_r == 3'h7) begin
          if (bytecnt_r != 3'h7) begin
            bytecnt_r <= bytecnt_r + 3'h1;
          end
          if (bytecnt_r == 3'h0) begin
            cmd_r <= byte_in;
            rd_sel_r <= fsw_sel(byte_in);
            reading_r <= fsw_is_rd(byte_in);
          end else if (bytecnt_r == 3'h1) begin
            data_r <= byte_in;
            addr_r <= {byte_in, addr_r[15:0]};
          end else if (bytecnt_r == 3'h2) begin
            addr_r <= {addr_r[23:16], byte_in, addr_r[7:0]};
          end else if (bytecnt_r == 3'h3) begin
            addr_r <= {addr_r[23:8], byte_in};
          end
        end
      end
      // Reload on each byte boundary so repeated bytes track busy live
      // The first falling edge after the opcode is the first that drives
      if (sclk_fall && reading_r) begin
        o_so_oe <= 1'b1;
        txcnt_r <= txcnt_r + 3'h1;
        if (txcnt_r == 3'h0) begin
          o_so <= rd_img[7];
          tx_r <= {rd_img[6:0], 1'b0};
        end else begin
          o_so <= tx_r[7];
          tx_r <= {tx_r[6:0], 1'b0};
        end
      end
    end
  end

  // Protection lookup on the captured address
  // Only its value at deselect matters, when all address bytes are in
  wire addr_prot;
  wire chip_ok;
  fsw_region u_region (
    .i_sel(region_r),
    .i_invert(invert_r),
    .i_addr(addr_r),
    .o_protected(addr_prot),
    .o_chip_ok(chip_ok)
  );

  // Lock-mode gate for status writes
  // Mode 10 relies on power-up reset clearing both lock bits; mode 11 is
  // only as permanent as the flops, which lose it at reset
  reg sr_wr_ok;
  always @* begin
    case ({lock_hi_r, lock_lo_r})
      2'b00: sr_wr_ok = 1'b1;
      2'b01: sr_wr_ok = wp_s;
      2'b10: sr_wr_ok = 1'b0;
      default: sr_wr_ok = 1'b0;
    endcase
  end

  // A command counts only when deselect lands on a byte boundary
  // Reads and cut frames fall through with nothing decoded, so a cut
  // frame never touches the latch
  wire exec = cs_end && (bitcnt_r == 3'h0) && (bytecnt_r != 3'h0);
  wire may_write = latch_r && !busy_w;
  wire is_wr_sr = (fsw_sel(cmd_r) != 2'h0) && !fsw_is_rd(cmd_r);
  wire is_wipe_mid = (cmd_r == `FSW_OP_WIPE_32K) || (cmd_r == `FSW_OP_WIPE_64K);
  wire is_wipe_all = (cmd_r == `FSW_OP_WIPE_ALL_A) || (cmd_r == `FSW_OP_WIPE_ALL_B);

  // Array-command acceptance, decided at deselect
  // Byte counts must match exactly, except page writes, which take any
  // length from five bytes on; the byte counter saturates at seven
  reg go_nxt;
  reg [1:0] kind_nxt;
  always @* begin
    go_nxt = 1'b0;
    kind_nxt = `FSW_KIND_PAGE;
    if (exec && may_write) begin
      if (cmd_r == `FSW_OP_PAGE && bytecnt_r >= 3'h5) begin
        go_nxt = !addr_prot;
      end else if (cmd_r == `FSW_OP_WIPE_4K && bytecnt_r == 3'h4) begin
        go_nxt = !addr_prot;
        kind_nxt = `FSW_KIND_SMALL;
      end else if (is_wipe_mid && bytecnt_r == 3'h4) begin
        go_nxt = !addr_prot;
        kind_nxt = `FSW_KIND_MID;
      end else if (is_wipe_all && bytecnt_r == 3'h1) begin
        go_nxt = chip_ok;
        kind_nxt = `FSW_KIND_WHOLE;
      end
    end
  end
  wire sr_go = exec && may_write && is_wr_sr && (bytecnt_r == 3'h2) && sr_wr_ok;

  // Status bits, latch, busy timer and array strobe
  reg rst_arm_r;
  always @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      lock_lo_r <= 1'b0;
      lock_hi_r <= 1'b0;
      region_r <= SR1_RST[6:2];
      invert_r <= 1'b0;
      latch_r <= 1'b0;
      busy_cnt_r <= 16'h0000;
      rst_arm_r <= 1'b0;
      o_array_go <= 1'b0;
      o_array_kind <= `FSW_KIND_PAGE;
      o_array_addr <= 24'h00_0000;
      o_busy_flag <= 1'b0;
      o_four_lane_on <= SR2_RST[`FSW_SR2_FOUR_LANE];
      o_drive_strength <= SR3_RST[6:5];
      o_latency_select <= SR3_RST[`FSW_SR3_LATENCY];
      o_pause_or_reset_select <= SR3_RST[`FSW_SR3_PIN_SEL];
      o_lock_otp <= SR2_RST[5:3];
    end else begin
      o_array_go <= go_nxt;
      // Busy output lags the internal timer by one clock
      o_busy_flag <= busy_w;
      if (go_nxt) begin
        o_array_kind <= kind_nxt;
        o_array_addr <= addr_r;
      end
      // Busy timer; latch drops as the operation completes
      if (go_nxt || sr_go) begin
        busy_cnt_r <= BUSY_CYC;
      end else if (busy_w) begin
        busy_cnt_r <= busy_cnt_r - 16'h0001;
        if (busy_cnt_r == 16'h0001) begin
          latch_r <= 1'b0;
        end
      end
      // A cut frame breaks the two-frame reset sequence as well
      if (cs_end && !exec) begin
        rst_arm_r <= 1'b0;
      end
      if (exec) begin
        rst_arm_r <= (cmd_r == `FSW_OP_RST_ARM) && (bytecnt_r == 3'h1);
        if (bytecnt_r == 3'h1 && cmd_r == `FSW_OP_LATCH_SET && !busy_w) begin
          latch_r <= 1'b1;
        end
        if (bytecnt_r == 3'h1 && cmd_r == `FSW_OP_LATCH_CLR && !busy_w) begin
          latch_r <= 1'b0;
        end
        // Software reset aborts the timer; stored bits survive it
        if (bytecnt_r == 3'h1 && cmd_r == `FSW_OP_RST_GO && rst_arm_r) begin
          latch_r <= 1'b0;
          busy_cnt_r <= 16'h0000;
        end
      end
      // Only path that changes the stored bits
      // Refused writes leave the latch set and start no busy stretch
      if (sr_go) begin
        case (fsw_sel(cmd_r))
          2'h1: begin
            lock_lo_r <= data_r[`FSW_SR1_LOCK_LO];
            region_r <= data_r[6:2];
          end
          // Security-area lock bits can only be set; a zero written to them is ignored
          2'h2: begin
            invert_r <= data_r[`FSW_SR2_INVERT];
            o_lock_otp <= o_lock_otp | data_r[5:3];
            o_four_lane_on <= data_r[`FSW_SR2_FOUR_LANE];
            lock_hi_r <= data_r[`FSW_SR2_LOCK_HI];
          end
          default: begin
            o_pause_or_reset_select <= data_r[`FSW_SR3_PIN_SEL];
            o_drive_strength <= data_r[6:5];
            o_latency_select <= data_r[`FSW_SR3_LATENCY];
          end
        endcase
      end
    end
  end

endmodule // fsw_top

// ===== tb/fsw_assertions.sv
// Port-level checks for the status and write-protect block.
// Assumes frames are at least ten clocks apart.
`timescale 1ns/1ns
module fsw_assertions #(
  parameter [15:0] BUSY_CYC = 16'h0064
) (
  input wire i_clk, // System clock
  input wire i_rst_n, // Reset, active low
  input wire i_cs_n, // Chip select
  input wire o_so_oe, // Serial out enable
  input wire o_array_go, // Array start pulse
  input wire o_busy_flag, // Busy flag
  input wire o_four_lane_on, // Config bit
  input wire [1:0] o_drive_strength, // Config field
  input wire o_latency_select, // Config bit
  input wire o_pause_or_reset_select, // Config bit
  input wire [2:0] o_lock_otp // One-time lock bits
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  // Busy stretch length, judged when it ends, since the count is too long to unroll
  logic [15:0] busy_run_r;
  wire [15:0] busy_run_nxt = o_busy_flag ? busy_run_r + 16'h0001 : 16'h0000;
  always @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) busy_run_r <= 16'h0000;
    else busy_run_r <= busy_run_nxt;
  end
  sequence go_then_busy;
    o_array_go ##[1:3] o_busy_flag;
  endsequence
  busy_after_go_a: assert property (o_array_go |-> go_then_busy)
    else $error("busy did not follow a start");
  busy_length_a: assert property ($fell(o_busy_flag) |-> busy_run_r == BUSY_CYC)
    else $error("busy stretch has wrong length");
  no_go_busy_a: assert property (o_busy_flag |-> !o_array_go)
    else $error("start while busy");
  otp_sticky_a: assert property (($past(o_lock_otp) & ~o_lock_otp) == 3'b000)
    else $error("lock bit cleared");
  cfg_quiet_a: assert property ($changed({o_four_lane_on, o_drive_strength,
    o_latency_select, o_pause_or_reset_select, o_lock_otp}) |-> i_cs_n)
    else $error("config changed inside a frame");
  oe_in_frame_a: assert property ($rose(o_so_oe) |-> !i_cs_n)
    else $error("serial out driven outside a frame");
  oe_release_a: assert property ($rose(i_cs_n) |-> ##6 !o_so_oe)
    else $error("serial out not released");
  drive_default_a: assert property ($rose(i_rst_n) |-> o_drive_strength == 2'b01)
    else $error("drive strength default wrong");
endmodule // fsw_assertions

bind fsw_top fsw_assertions #(.BUSY_CYC(BUSY_CYC)) chk_u (.i_clk, .i_rst_n, .i_cs_n,
  .o_so_oe, .o_array_go, .o_busy_flag, .o_four_lane_on, .o_drive_strength,
  .o_latency_select, .o_pause_or_reset_select, .o_lock_otp);

// ===== tb/fsw_host_model.sv
// Serial host model: mode 0 frames, MSB first, 160 ns bit time.
// Assumes i_clk is the 50 MHz bench clock; pins change at its falling edge.
`timescale 1ns/1ns
module fsw_host_model (
  input wire i_clk, // Bench clock
  input wire i_so, // Serial data from block
  input wire i_so_oe, // Block drives serial out
  output logic o_sclk, // Serial clock, idles low
  output logic o_cs_n, // Chip select, active low
  output logic o_si // Serial data to block
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end
  // Shift nb bits out; rx keeps the last eight bits, inverse of so where not driven
  task automatic xfer(input logic [39:0] tx, input int nb, output logic [7:0] rx);
    rx = 8'h00;
    @(negedge i_clk);
    o_cs_n = 1'b0;
    for (int i = 0; i < nb; i++) begin
      o_si = tx[39 - i];
      repeat (4) @(negedge i_clk);
      o_sclk = 1'b1;
      repeat (4) @(negedge i_clk);
      rx = {rx[6:0], i_so_oe ? i_so : ~i_so};
      o_sclk = 1'b0;
    end
    repeat (4) @(negedge i_clk);
    o_cs_n = 1'b1;
    o_si = ~o_si; // Released line shows the inverse, never a stale bit
    repeat (12) @(negedge i_clk);
  endtask
endmodule // fsw_host_model

// ===== tb/testbench.sv
// Self-checking bench for the status and write-protect block.
// Assumes the host model frames every command; expectations come from the bit map.
`timescale 1ns/1ns
module testbench;
  logic clk, rst_n, wp_n, ers_p, prg_p;
  wire sclk, cs_n, si, so, so_oe, go, busy, four, lat, pin_sel;
  wire [1:0] kind, drv;
  wire [23:0] addr;
  wire [2:0] otp;
  logic [7:0] s [0:2];
  logic [7:0] rx;
  logic [1:0] gkind;
  logic [23:0] gaddr;
  int miscompares = 0;
  int total_checks = 0;
  int gos = 0;
  int cyc = 0;
  fsw_top #(.BUSY_CYC(16'h012C)) dut (.i_clk(clk), .i_rst_n(rst_n), .i_sclk(sclk),
    .i_cs_n(cs_n), .i_si(si), .i_wp_n(wp_n), .i_erase_paused(ers_p),
    .i_prog_paused(prg_p), .o_so(so), .o_so_oe(so_oe), .o_array_go(go),
    .o_array_kind(kind), .o_array_addr(addr), .o_busy_flag(busy),
    .o_four_lane_on(four), .o_drive_strength(drv), .o_latency_select(lat),
    .o_pause_or_reset_select(pin_sel), .o_lock_otp(otp));
  fsw_host_model host (.i_clk(clk), .i_so(so), .i_so_oe(so_oe), .o_sclk(sclk),
    .o_cs_n(cs_n), .o_si(si));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Record array starts; cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (go === 1'b1) begin
      gos <= gos + 1;
      gkind <= kind;
      gaddr <= addr;
    end
    if (cyc == 60000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmd(input logic [39:0] tx, input int nb);
    host.xfer(tx, nb, rx);
  endtask
  task automatic rd(input logic [7:0] op, input logic [7:0] exp);
    host.xfer({op, 32'h0000_0000}, 16, rx);
    chk({24'h00_0000, rx}, {24'h00_0000, exp});
  endtask
  // Wait out busy, then drop a latch that a refused command left set
  task automatic idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    if (n == 1000) miscompares++;
    cmd({8'h04, 32'h0000_0000}, 8);
  endtask
  task automatic reset_dut();
    rst_n = 1'b0;
    repeat (20) @(negedge clk);
    rst_n = 1'b1;
    repeat (10) @(negedge clk);
    s[0] = 8'h00;
    s[1] = 8'h00;
    s[2] = 8'h20;
  endtask
  // Status write after latch set; ok says whether the lock mode lets it land
  task automatic wr(input logic [7:0] op, input logic [7:0] d, input bit ok);
    int i;
    i = (op == 8'h01) ? 0 : (op == 8'h31) ? 1 : 2;
    cmd({8'h06, 32'h0000_0000}, 8);
    cmd({op, d, 24'h00_0000}, 16);
    if (ok) s[i] = (i == 0) ? d & 8'hFC : (i == 1) ? (d & 8'h7B) | (s[1] & 8'h38) : d & 8'hE1;
    rd(8'h05, s[0] | (ok ? 8'h03 : 8'h02));
    idle();
    rd(op + 8'h04, s[i]);
  endtask
  // One array command after latch set; ok says whether a start is due
  task automatic arr(input logic [7:0] op, input logic [23:0] a, input int nb, input bit ok,
    input logic [1:0] k);
    int g;
    g = gos;
    cmd({8'h06, 32'h0000_0000}, 8);
    cmd({op, a, 8'h5A}, nb);
    chk(gos - g, ok);
    if (ok) chk({gkind, (k == 2'h3) ? 24'h00_0000 : gaddr},
      {k, (k == 2'h3) ? 24'h00_0000 : a});
    rd(8'h05, s[0] | (ok ? 8'h03 : 8'h02));
    idle();
  endtask
  initial begin
    rst_n = 1'b0;
    wp_n = 1'b1;
    ers_p = 1'b0;
    prg_p = 1'b0;
    reset_dut();
    rd(8'h05, 8'h00);
    rd(8'h35, 8'h00);
    rd(8'h15, 8'h20);
    chk(drv, 2'b01);
    ers_p = 1'b1;
    prg_p = 1'b1;
    rd(8'h35, 8'h84);
    ers_p = 1'b0;
    prg_p = 1'b0;
    cmd({8'h01, 8'hFC, 24'h00_0000}, 16);
    rd(8'h05, 8'h00);
    cmd({8'h06, 32'h0000_0000}, 8);
    rd(8'h05, 8'h02);
    cmd({8'h04, 32'h0000_0000}, 8);
    rd(8'h05, 8'h00);
    // A cut latch-set frame is ignored; a cut frame also disarms software reset
    cmd({8'h06, 32'h0000_0000}, 7);
    rd(8'h05, 8'h00);
    cmd({8'h06, 32'h0000_0000}, 8);
    cmd({8'h66, 32'h0000_0000}, 8);
    cmd({8'h99, 32'h0000_0000}, 4);
    cmd({8'h99, 32'h0000_0000}, 8);
    rd(8'h05, 8'h02);
    cmd({8'h66, 32'h0000_0000}, 8);
    cmd({8'h99, 32'h0000_0000}, 8);
    rd(8'h05, 8'h00);
    wr(8'h11, 8'hFF, 1'b1);
    chk({pin_sel, drv, lat}, 4'hF);
    wr(8'h31, 8'h3A, 1'b1);
    chk({otp, four}, 4'hF);
    wr(8'h31, 8'h00, 1'b1);
    // Upper sixty-fourth, then bottom 4KB, then its complement
    wr(8'h01, 8'h07, 1'b1);
    arr(8'h02, 24'hFC_0000, 40, 1'b0, 2'h0);
    arr(8'h02, 24'hFB_FFFF, 40, 1'b1, 2'h0);
    arr(8'h60, 24'h00_0000, 8, 1'b0, 2'h3);
    wr(8'h01, 8'h64, 1'b1);
    arr(8'h20, 24'h00_1000, 32, 1'b1, 2'h1);
    arr(8'h52, 24'h00_0800, 32, 1'b0, 2'h2);
    arr(8'hD8, 24'hFF_0000, 32, 1'b1, 2'h2);
    wr(8'h31, 8'h40, 1'b1);
    arr(8'h20, 24'h00_0000, 32, 1'b1, 2'h1);
    arr(8'h20, 24'hFF_F000, 32, 1'b0, 2'h1);
    wr(8'h01, 8'h1C, 1'b1);
    arr(8'hC7, 24'h00_0000, 8, 1'b1, 2'h3);
    wr(8'h31, 8'h00, 1'b1);
    arr(8'h60, 24'h00_0000, 8, 1'b0, 2'h3);
    wr(8'h01, 8'h00, 1'b1);
    arr(8'h60, 24'h00_0000, 8, 1'b1, 2'h3);
    // Lock modes against the protect pin
    wp_n = 1'b0;
    wr(8'h01, 8'h80, 1'b1);
    wr(8'h01, 8'h84, 1'b0);
    wp_n = 1'b1;
    wr(8'h01, 8'h84, 1'b1);
    wr(8'h31, 8'h01, 1'b1);
    wr(8'h01, 8'h00, 1'b0);
    reset_dut();
    rd(8'h35, 8'h00);
    wr(8'h31, 8'h01, 1'b1);
    wr(8'h01, 8'h04, 1'b0);
    reset_dut();
    rd(8'h35, 8'h00);
    tally_and_finish();
  end
endmodule // testbench
